/* File: rtl/quad_burst_pkg.sv */
// Shared constants for the burst-of-four separate-port static memory
package quad_burst_pkg;

  // ==========================================================
  // Organisation of the two variants
  localparam int WIDE_DATA_W    = 36;
  localparam int WIDE_ADDR_W    = 19;
  localparam int NARROW_DATA_W  = 18;
  localparam int NARROW_ADDR_W  = 20;
  localparam int WIDE_DEPTH     = 524288;
  localparam int NARROW_DEPTH   = 1048576;
  localparam int LANE_W         = 9;

  // ==========================================================
  // Burst shape and pipeline timing, in mclk cycles
  // (one mclk cycle stands for one input clock edge, true or complement)
  localparam int          BURST_LEN   = 4;
  localparam int          BEAT_W      = 2;
  localparam logic [1:0]  BEAT_FIRST  = 2'h0;
  localparam logic [1:0]  BEAT_BLOCK  = 2'h1;
  localparam logic [1:0]  BEAT_LAST   = 2'h3;
  localparam int          SYNC_STAGES = 2;
  localparam logic [1:0]  STRAP_WAIT  = 2'h3;

  // ==========================================================
  // Reset values
  localparam logic        ECHO_RST    = 1'b0;

  // ==========================================================
  // Engine states
  typedef enum logic [1:0] {
    RD_IDLE  = 2'b01,
    RD_BURST = 2'b10
  } rd_state_t;

  typedef enum logic [2:0] {
    WR_IDLE  = 3'b001,
    WR_LATE  = 3'b010,
    WR_BURST = 3'b100
  } wr_state_t;

endpackage

/* File: rtl/pin_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* File: rtl/burst_mem.sv */
// Storage array with byte-lane writes and a registered read port
`timescale 1ns/1ps
module burst_mem #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 20,
  parameter int DEPTH  = 1048576,
  parameter int LANE_W = 9
) (
  input  wire logic                     mclk,
  input  wire logic                     wrEn,
  input  wire logic [ADDR_W-1:0]        wrAddr,
  input  wire logic [DATA_W-1:0]        wrData,
  input  wire logic [DATA_W/LANE_W-1:0] laneEn,
  input  wire logic [ADDR_W-1:0]        rdAddr,
  output logic      [DATA_W-1:0]        rdData
);

  localparam int LANES = DATA_W / LANE_W;

  if (DATA_W % LANE_W != 0 || DEPTH > (1 << ADDR_W) || DEPTH < 1) begin : gBadGeometry
    $error("burst_mem: unsupported geometry");
  end

  logic [DATA_W-1:0] mem [DEPTH];

  // Each enabled lane stores its own slice of the word
  always_ff @(posedge mclk) begin
    for (int l = 0; l < LANES; l++) begin
      if (wrEn && laneEn[l]) begin
        mem[wrAddr][l*LANE_W +: LANE_W] <= wrData[l*LANE_W +: LANE_W];
      end
    end
  end

  // Read port answers one cycle after the address
  always_ff @(posedge mclk) begin
    rdData <= mem[rdAddr];
  end

endmodule

/* File: rtl/quad_burst_sram.sv */
// Burst-of-four static memory with separate read and write data ports
`timescale 1ns/1ps
module quad_burst_sram
  import quad_burst_pkg::*;
#(
  parameter int WIDE   = 0,
  parameter int DATA_W = (WIDE != 0) ? WIDE_DATA_W : NARROW_DATA_W,
  parameter int ADDR_W = (WIDE != 0) ? WIDE_ADDR_W : NARROW_ADDR_W,
  parameter int DEPTH  = (WIDE != 0) ? WIDE_DEPTH  : NARROW_DEPTH,
  parameter int LANES  = DATA_W / LANE_W
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              inClkTrue,
  input  wire logic              readSel_n,
  input  wire logic              writeSel_n,
  input  wire logic [ADDR_W-1:0] sharedAddressBus,
  input  wire logic [DATA_W-1:0] writeDataIn,
  input  wire logic [LANES-1:0]  byteLaneWrite_n,
  input  wire logic              outClk,
  input  wire logic              outClkBar,
  input  wire logic              dllOff_n,
  output logic      [DATA_W-1:0] readDataOut,
  output logic                   readDataOe,
  output logic                   echoStrobePair,
  output logic                   echoStrobePairBar,
  output logic                   dllEnabled,
  output logic                   singleClockMode
);

  // ==========================================================
  // Elaboration checks
  // Refuse geometries that the lane gating or the array cannot serve
  if (DATA_W != LANES * LANE_W) begin : gBadLanes
    $error("quad_burst_sram: data width must be whole lanes");
  end
  if (DEPTH * DATA_W != WIDE_DEPTH * WIDE_DATA_W) begin : gBadDepth
    $error("quad_burst_sram: array must be one of the two variants");
  end
  if (DEPTH > (1 << ADDR_W) || ADDR_W <= BEAT_W) begin : gBadAddr
    $error("quad_burst_sram: address too narrow for the depth");
  end

  // ==========================================================
  // Input pin synchronisers
  localparam int CTL_W = 6;
  localparam logic [CTL_W-1:0] CTL_RST = 6'h3E;

  logic [CTL_W-1:0]  ctlSync;
  logic [ADDR_W-1:0] addrS;
  logic [DATA_W-1:0] wdataS;
  logic [LANES-1:0]  laneS_n;
  logic              trueEdge;
  logic              readSelS_n;
  logic              writeSelS_n;
  logic              outClkS;
  logic              outClkBarS;
  logic              dllOffS_n;

  // All controller inputs share one depth so they stay aligned
  pin_sync #(.W(CTL_W), .RST_VAL(CTL_RST)) uCtlSync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     ({dllOff_n, outClkBar, outClk, writeSel_n, readSel_n, inClkTrue}),
    .q     (ctlSync)
  );

  pin_sync #(.W(ADDR_W)) uAddrSync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     (sharedAddressBus),
    .q     (addrS)
  );

  pin_sync #(.W(DATA_W)) uDataSync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     (writeDataIn),
    .q     (wdataS)
  );

  // Lane enables reset deasserted so nothing stores while the flops fill
  pin_sync #(.W(LANES), .RST_VAL({LANES{1'b1}})) uLaneSync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .d     (byteLaneWrite_n),
    .q     (laneS_n)
  );

  assign trueEdge    = ctlSync[0];
  assign readSelS_n  = ctlSync[1];
  assign writeSelS_n = ctlSync[2];
  assign outClkS     = ctlSync[3];
  assign outClkBarS  = ctlSync[4];
  assign dllOffS_n   = ctlSync[5];

  // ==========================================================
  // Delay-locked loop control
  // Loop state follows the disable pin after synchronisation
  // The loop has no timing effect here; only its state is reported
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dllEnabled <= 1'b1;
    end else begin
      dllEnabled <= dllOffS_n;
    end
  end

  // ==========================================================
  // Output clock mode strap
  logic [1:0] strapCnt_q;
  logic       strapDone_q;

  // Wait for the synchroniser to fill, then catch the mode once
  // A later change on the output clock pins is not followed
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      strapCnt_q      <= 2'h0;
      strapDone_q     <= 1'b0;
      singleClockMode <= 1'b0;
    end else if (!strapDone_q) begin
      strapCnt_q <= strapCnt_q + 2'h1;
      if (strapCnt_q == STRAP_WAIT) begin
        strapDone_q     <= 1'b1;
        singleClockMode <= outClkS & outClkBarS;
      end
    end
  end

  // ==========================================================
  // Read engine
  rd_state_t         rdState_q;
  logic [1:0]        rdBeat_q;
  logic [ADDR_W-1:0] rdBase_q;
  logic              rdAccept;
  logic              rdIssue;
  logic [ADDR_W-1:0] rdAddr;

  // A read is taken on a true edge when its port is selected and free
  // Beat one is the next true edge; beat three admits a follow-on read
  assign rdAccept = trueEdge && !readSelS_n
                    && !(rdState_q == RD_BURST && rdBeat_q == BEAT_BLOCK);

  // Read address register and four-beat counter
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdState_q <= RD_IDLE;
      rdBeat_q  <= BEAT_FIRST;
      rdBase_q  <= '0;
    end else begin
      case (rdState_q)
        RD_IDLE: begin
          if (rdAccept) begin
            rdState_q <= RD_BURST;
            rdBase_q  <= addrS;
            rdBeat_q  <= BEAT_FIRST;
          end
        end
        RD_BURST: begin
          rdBeat_q <= rdBeat_q + 2'h1;
          if (rdBeat_q == BEAT_LAST) begin
            if (rdAccept) begin
              rdBase_q <= addrS;
            end else begin
              rdState_q <= RD_IDLE;
            end
          end
        end
        default: begin
          rdState_q <= RD_IDLE;
        end
      endcase
    end
  end

  // Two-bit linear count inside the burst
  assign rdIssue = (rdState_q == RD_BURST);
  assign rdAddr  = {rdBase_q[ADDR_W-1:BEAT_W], rdBase_q[BEAT_W-1:0] + rdBeat_q};

  // ==========================================================
  // Write engine
  wr_state_t         wrState_q;
  logic [1:0]        wrBeat_q;
  logic [ADDR_W-1:0] wrBase_q;
  logic [ADDR_W-1:0] wrNext_q;
  logic              wrPend_q;
  logic              wrAccept;
  logic              wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [LANES-1:0]  laneEn;

  // A write is taken on a true edge unless one started on the last true edge
  // A command caught in mid-burst waits in wrNext_q until beat three
  assign wrAccept = trueEdge && !writeSelS_n
                    && (wrState_q != WR_LATE) && !wrPend_q
                    && !(wrState_q == WR_BURST && wrBeat_q == BEAT_FIRST);

  // Late write: the first word arrives on the true edge after the command
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wrState_q <= WR_IDLE;
      wrBeat_q  <= BEAT_FIRST;
      wrBase_q  <= '0;
      wrNext_q  <= '0;
      wrPend_q  <= 1'b0;
    end else begin
      case (wrState_q)
        WR_IDLE: begin
          if (wrAccept) begin
            wrState_q <= WR_LATE;
            wrBase_q  <= addrS;
          end
        end
        WR_LATE: begin
          wrState_q <= WR_BURST;
          wrBeat_q  <= BEAT_FIRST;
        end
        WR_BURST: begin
          wrBeat_q <= wrBeat_q + 2'h1;
          if (wrAccept) begin
            wrPend_q <= 1'b1;
            wrNext_q <= addrS;
          end
          if (wrBeat_q == BEAT_LAST) begin
            wrPend_q <= 1'b0;
            if (wrPend_q) begin
              wrBase_q <= wrNext_q;
            end else begin
              wrState_q <= WR_IDLE;
            end
          end
        end
        default: begin
          wrState_q <= WR_IDLE;
        end
      endcase
    end
  end

  // One word stored per input clock edge, lanes gated by their enables
  assign wrEn   = (wrState_q == WR_BURST);
  assign wrAddr = {wrBase_q[ADDR_W-1:BEAT_W], wrBase_q[BEAT_W-1:0] + wrBeat_q};
  assign laneEn = ~laneS_n;

  // ==========================================================
  // Storage
  // A read and a write of one word in one cycle return the old word
  logic [DATA_W-1:0] memData;

  burst_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W),
    .DEPTH  (DEPTH),
    .LANE_W (LANE_W)
  ) uMem (
    .mclk   (mclk),
    .wrEn   (wrEn),
    .wrAddr (wrAddr),
    .wrData (wdataS),
    .laneEn (laneEn),
    .rdAddr (rdAddr),
    .rdData (memData)
  );

  // ==========================================================
  // Read output pipeline
  logic              rdValid_q;
  logic [DATA_W-1:0] stage_q;
  logic              stageValid_q;

  // Track which array answers belong to a burst, plus one extra stage
  // that lets the separate output clocks launch a half cycle later
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdValid_q    <= 1'b0;
      stage_q      <= '0;
      stageValid_q <= 1'b0;
    end else begin
      rdValid_q    <= rdIssue;
      stage_q      <= memData;
      stageValid_q <= rdValid_q;
    end
  end

  // Words leave back to back; drivers release when no word is due
  // Single clock mode skips the extra stage and launches a half cycle early
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      readDataOut <= '0;
      readDataOe  <= 1'b0;
    end else if (singleClockMode) begin
      readDataOut <= memData;
      readDataOe  <= rdValid_q;
    end else begin
      readDataOut <= stage_q;
      readDataOe  <= stageValid_q;
    end
  end

  // ==========================================================
  // Echo strobes
  // Free-running pair in its own flops, clocked on every mclk edge like the data outputs
  // Toggling from reset keeps the pair running between reads
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      echoStrobePair    <= ECHO_RST;
      echoStrobePairBar <= ~ECHO_RST;
    end else begin
      echoStrobePair    <= ~echoStrobePair;
      echoStrobePairBar <= echoStrobePair;
    end
  end

endmodule

/* File: verif/quad_burst_sram_checker.sv */
// Concurrent checks on the ports of the burst-of-four static memory
`timescale 1ns/1ps
module quad_burst_sram_checker #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 18,
  parameter int LANES  = 2
) (
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              inClkTrue,
  input wire logic              readSel_n,
  input wire logic              writeSel_n,
  input wire logic [ADDR_W-1:0] sharedAddressBus,
  input wire logic [DATA_W-1:0] writeDataIn,
  input wire logic [LANES-1:0]  byteLaneWrite_n,
  input wire logic              outClk,
  input wire logic              outClkBar,
  input wire logic              dllOff_n,
  input wire logic [DATA_W-1:0] readDataOut,
  input wire logic              readDataOe,
  input wire logic              echoStrobePair,
  input wire logic              echoStrobePairBar,
  input wire logic              dllEnabled,
  input wire logic              singleClockMode
);
  logic [3:0] sinceRst_q;
  logic [3:0] runCnt_q;

  // ==========================================================
  // Helpers: edges since reset release, length of the read-data run
  always_ff @(posedge mclk) begin
    if (!rst_b)
      sinceRst_q <= 4'h0;
    else if (sinceRst_q != 4'hF)
      sinceRst_q <= sinceRst_q + 4'h1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b)
      runCnt_q <= 4'h0;
    else
      runCnt_q <= readDataOe ? runCnt_q + 4'h1 : 4'h0;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // Assertions
  property p_echo_toggle;
    $past(rst_b) |-> echoStrobePair != $past(echoStrobePair);
  endproperty
  a_echo_toggle: assert property (p_echo_toggle)
    else $error("echo strobe held still");
  property p_echo_pair;
    echoStrobePairBar == !echoStrobePair;
  endproperty
  a_echo_pair: assert property (p_echo_pair)
    else $error("echo strobes not complementary");
  property p_run_len;
    $fell(readDataOe) |-> runCnt_q[1:0] == 2'h0;
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("read data run not whole bursts");
  property p_rd_lat_sc;
    singleClockMode && inClkTrue && !readSel_n && $past(readSel_n, 2) |->
      ##5 readDataOe [*4];
  endproperty
  a_rd_lat_sc: assert property (p_rd_lat_sc)
    else $error("read data late in single clock mode");
  property p_rd_lat_oc;
    !singleClockMode && inClkTrue && !readSel_n && $past(readSel_n, 2) |->
      ##6 readDataOe [*4];
  endproperty
  a_rd_lat_oc: assert property (p_rd_lat_oc)
    else $error("read data late in output clock mode");
  property p_mode_strap;
    sinceRst_q > 4'h7 |-> singleClockMode == (outClk && outClkBar);
  endproperty
  a_mode_strap: assert property (p_mode_strap)
    else $error("clock mode does not match strap");
  property p_mode_static;
    sinceRst_q > 4'h7 |-> $stable(singleClockMode);
  endproperty
  a_mode_static: assert property (p_mode_static)
    else $error("clock mode changed");
  property p_dll;
    sinceRst_q > 4'h4 |-> dllEnabled == $past(dllOff_n, 3);
  endproperty
  a_dll: assert property (p_dll)
    else $error("loop enable does not follow pin");
  property p_deselect;
    readSel_n [*8] |-> ##2 !readDataOe;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("read drivers on without a read");
endmodule

bind quad_burst_sram quad_burst_sram_checker #(
  .ADDR_W(ADDR_W), .DATA_W(DATA_W), .LANES(LANES)
) u_quad_burst_sram_checker (
  .mclk(mclk), .rst_b(rst_b), .inClkTrue(inClkTrue), .readSel_n(readSel_n),
  .writeSel_n(writeSel_n), .sharedAddressBus(sharedAddressBus),
  .writeDataIn(writeDataIn), .byteLaneWrite_n(byteLaneWrite_n), .outClk(outClk),
  .outClkBar(outClkBar), .dllOff_n(dllOff_n), .readDataOut(readDataOut),
  .readDataOe(readDataOe), .echoStrobePair(echoStrobePair),
  .echoStrobePairBar(echoStrobePairBar), .dllEnabled(dllEnabled),
  .singleClockMode(singleClockMode)
);

/* File: verif/ctrl_model.sv */
// Memory controller model: input clock phase, commands and write data
`timescale 1ns/1ps
module ctrl_model #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 18,
  parameter int LANES  = 2
) (
  input  wire logic              mclk,
  output logic                   inClkTrue,
  output logic                   readSel_n,
  output logic                   writeSel_n,
  output logic      [ADDR_W-1:0] sharedAddressBus,
  output logic      [DATA_W-1:0] writeDataIn,
  output logic      [LANES-1:0]  byteLaneWrite_n
);
  // Idle levels: selects and lane enables deasserted high
  initial begin
    inClkTrue        = 1'b0;
    readSel_n        = 1'b1;
    writeSel_n       = 1'b1;
    sharedAddressBus = '0;
    writeDataIn      = '0;
    byteLaneWrite_n  = '1;
  end

  // True and complement input edges alternate
  always @(posedge mclk)
    inClkTrue <= ~inClkTrue;

  // Wait for the edge that launches a true-edge cycle
  task automatic wait_true;
    @(posedge mclk);
    while (inClkTrue)
      @(posedge mclk);
  endtask

  // Read command; the released address shows its inverse
  task automatic rd(input logic [ADDR_W-1:0] a);
    wait_true();
    readSel_n        <= 1'b0;
    sharedAddressBus <= a;
    @(posedge mclk);
    readSel_n        <= 1'b1;
    sharedAddressBus <= ~a;
  endtask

  // Write command, then four words on alternating true and complement edges
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [4*DATA_W-1:0] d,
                    input logic [4*LANES-1:0] l);
    wait_true();
    writeSel_n       <= 1'b0;
    sharedAddressBus <= a;
    @(posedge mclk);
    writeSel_n       <= 1'b1;
    sharedAddressBus <= ~a;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      writeDataIn     <= d[k*DATA_W +: DATA_W];
      byteLaneWrite_n <= l[k*LANES +: LANES];
    end
    @(posedge mclk);
    writeDataIn     <= ~writeDataIn;
    byteLaneWrite_n <= '1;
  endtask
endmodule

/* File: verif/test_quad_burst_sram.sv */
// Self-checking testbench for the burst-of-four static memory
`timescale 1ns/1ps
module test_quad_burst_sram;
  import quad_burst_pkg::*;
  localparam int DW = NARROW_DATA_W;
  localparam int AW = NARROW_ADDR_W;
  localparam int LN = NARROW_DATA_W / LANE_W;
  localparam logic [AW-1:0] WRA = 20'h00012;
  localparam logic [AW-1:0] RDA = 20'h00010;
  localparam logic [DW-1:0] W0 = 18'h1A001;
  localparam logic [DW-1:0] W1 = 18'h2B002;
  localparam logic [DW-1:0] W2 = 18'h3C003;
  localparam logic [DW-1:0] W3 = 18'h0D004;
  localparam logic [DW-1:0] X1 = 18'h2AAAA;
  localparam logic [DW-1:0] X2 = 18'h0F0F0;

  logic          mclk, rst_b, inClkTrue, readSel_n, writeSel_n, outClk, outClkBar;
  logic          dllOff_n, readDataOe, echoStrobePair, echoStrobePairBar;
  logic          dllEnabled, singleClockMode;
  logic [AW-1:0] sharedAddressBus;
  logic [DW-1:0] writeDataIn, readDataOut;
  logic [LN-1:0] byteLaneWrite_n;
  logic [4*DW-1:0] memImg;
  int            err_count = 0;
  int            checks = 0;
  int            cyc = 0;

  // Clock, strap and loop pin at time zero
  initial begin
    mclk      = 1'b0;
    rst_b     = 1'b0;
    outClk    = 1'b1;
    outClkBar = 1'b1;
    dllOff_n  = 1'b1;
  end
  always #4 mclk = ~mclk;

  quad_burst_sram u_quad_burst_sram (
    .mclk(mclk), .rst_b(rst_b), .inClkTrue(inClkTrue), .readSel_n(readSel_n),
    .writeSel_n(writeSel_n), .sharedAddressBus(sharedAddressBus),
    .writeDataIn(writeDataIn), .byteLaneWrite_n(byteLaneWrite_n), .outClk(outClk),
    .outClkBar(outClkBar), .dllOff_n(dllOff_n), .readDataOut(readDataOut),
    .readDataOe(readDataOe), .echoStrobePair(echoStrobePair),
    .echoStrobePairBar(echoStrobePairBar), .dllEnabled(dllEnabled),
    .singleClockMode(singleClockMode)
  );
  ctrl_model u_ctrl_model (
    .mclk(mclk), .inClkTrue(inClkTrue), .readSel_n(readSel_n),
    .writeSel_n(writeSel_n), .sharedAddressBus(sharedAddressBus),
    .writeDataIn(writeDataIn), .byteLaneWrite_n(byteLaneWrite_n)
  );

  // ==========================================================
  // Comparison, verdict and hang guard
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end

  // ==========================================================
  // Scenarios
  task automatic do_reset(input logic sc);
    @(posedge mclk);
    rst_b     <= 1'b0;
    outClk    <= sc;
    outClkBar <= sc;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    chk(DW'(singleClockMode), DW'(sc));
  endtask

  // Read one burst, check latency, four words in order, then release
  task automatic rd_chk(input logic [AW-1:0] a, input logic [4*DW-1:0] exp, input int lat);
    int n;
    n = 1;
    u_ctrl_model.rd(a);
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (readDataOe !== 1'b1 && n < 12);
    chk(DW'(n), DW'(lat));
    for (int k = 0; k < 4; k++) begin
      chk(readDataOut, exp[k*DW +: DW]);
      chk(DW'(readDataOe), DW'(1));
      @(posedge mclk);
      #1;
    end
    chk(DW'(readDataOe), DW'(0));
  endtask

  // Full write at an offset base, read back from the aligned base
  task automatic s_basic;
    u_ctrl_model.wr(WRA, {W3, W2, W1, W0}, 8'h00);
    repeat (4) @(posedge mclk);
    rd_chk(RDA, {W1, W0, W3, W2}, 5);
  endtask

  // Lane-masked write racing a read of the same burst
  task automatic s_lanes;
    memImg = {W1, W0[17:9], X2[8:0], X1[17:9], W3[8:0], 18'h15555};
    fork
      rd_chk(RDA, {W1, W0, W3, W2}, 5);
      begin
        // Write goes one true edge later so the shared bus has one driver
        repeat (2) @(posedge mclk);
        u_ctrl_model.wr(RDA, {18'h30303, X2, X1, 18'h15555}, 8'hE4);
      end
    join
    repeat (4) @(posedge mclk);
    rd_chk(RDA, memImg, 5);
  endtask

  // Two reads a gap apart; measure the length of the data run
  task automatic s_runs(input int gap, input int exp);
    int n;
    int len;
    n = 0;
    len = 0;
    fork
      begin
        u_ctrl_model.rd(RDA);
        repeat (gap) @(posedge mclk);
        u_ctrl_model.rd(RDA);
      end
      begin
        while (readDataOe !== 1'b1 && n < 20) begin
          @(posedge mclk);
          #1;
          n++;
        end
        while (readDataOe === 1'b1 && len < 20) begin
          @(posedge mclk);
          #1;
          len++;
        end
      end
    join
    chk(DW'(len), DW'(exp));
  endtask

  // Echo strobes and loop disable pin
  task automatic s_misc;
    logic e;
    @(posedge mclk);
    #1;
    e = echoStrobePair;
    @(posedge mclk);
    #1;
    chk(DW'(echoStrobePair), DW'(!e));
    chk(DW'(echoStrobePairBar), DW'(e));
    @(posedge mclk);
    dllOff_n <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    chk(DW'(dllEnabled), DW'(0));
    @(posedge mclk);
    dllOff_n <= 1'b1;
  endtask

  // Main sequence
  initial begin
    do_reset(1'b1);
    s_basic();
    s_lanes();
    s_runs(0, 4);
    s_runs(2, 8);
    s_misc();
    do_reset(1'b0);
    rd_chk(RDA, memImg, 6);
    give_verdict();
  end
endmodule
